// ==== verilog/ipm_pkg.sv ====
// Purpose: shared constants and types for the interrupt priority mask unit
// Assumes: 100 MHz system clock, 32-bit classic wishbone register bus
// Notes: vector numbers, register offsets and reset values live here
package ipm_pkg;
  localparam int IPM_NSRC = 19;
  localparam int IPM_VW = 6;
  // register byte offsets
  localparam logic [3:0] IPM_OFF_SYSCTL = 4'h0;
  localparam logic [3:0] IPM_OFF_PRIA = 4'h4;
  localparam logic [3:0] IPM_OFF_PRIB = 4'h8;
  localparam logic [3:0] IPM_OFF_ENABLE = 4'hC;
  // reset values
  localparam logic [7:0] IPM_PRI_RST = 8'h00;
  localparam logic [19:0] IPM_EN_RST = 20'h00000;
  localparam logic [1:0] IPM_SYSCTL_RST = 2'h2;
  // system control fields
  localparam int IPM_SYS_MODE_BIT = 1;
  localparam int IPM_SYS_EDGE_BIT = 0;
  // vector numbers
  localparam logic [5:0] IPM_VEC_NMI = 6'h07;
  // per source vector, in fixed tie-break order (index 0 wins)
  localparam logic [IPM_NSRC*6-1:0] IPM_VEC_TABLE = {
    6'h3C, 6'h3B, 6'h3A, 6'h39, 6'h38, 6'h37, 6'h36, 6'h35, 6'h34,
    6'h2A, 6'h29, 6'h28, 6'h26, 6'h25, 6'h24, 6'h11, 6'h10, 6'h0D, 6'h0C};
  // priority bit select per source: 0..2 prio a bits 7,6,4; 3.. prio b bits
  localparam logic [IPM_NSRC*4-1:0] IPM_GRP_TABLE = {
    4'h7, 4'h6, 4'h6, 4'h6, 4'h6, 4'h5, 4'h5, 4'h5, 4'h5,
    4'h4, 4'h4, 4'h4, 4'h3, 4'h3, 4'h3, 4'h2, 4'h2, 4'h1, 4'h0};
  typedef enum logic [1:0] {
    IPM_ST_IDLE = 2'b00,
    IPM_ST_OFFER = 2'b01,
    IPM_ST_ENTRY = 2'b11
  } ipm_state_t;
endpackage

// ==== verilog/ipm_sel_if.sv ====
`timescale 1ns/1ps
// Purpose: carries arbitration result from arbiter to controller
// Assumes: one clock domain
// Notes: sel_vec is registered inside the arbiter
interface ipm_sel_if;
  logic sel_valid;
  logic sel_level;
  logic [5:0] sel_vec;
  modport arb (output sel_valid, output sel_level, output sel_vec);
  modport ctl (input sel_valid, input sel_level, input sel_vec);
endinterface

// ==== verilog/ipm_arbiter.sv ====
`timescale 1ns/1ps
// Purpose: picks highest level, then lowest vector, among pending sources
// Assumes: req_i already gated by enables and masks
// Notes: result registered, one cycle latency
module ipm_arbiter
  import ipm_pkg::*;
#(
  parameter int NSRC = IPM_NSRC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [NSRC-1:0] req_i,
  input wire logic [NSRC-1:0] lvl_i,
  ipm_sel_if.arb sel
);
  logic [NSRC-1:0] hi_req;
  logic [NSRC-1:0] use_req;
  logic any_hi;
  logic found;
  logic [5:0] pick;
  assign hi_req = req_i & lvl_i;
  assign any_hi = |hi_req;
  assign use_req = any_hi ? hi_req : req_i; // level 1 outranks level 0
  always_comb begin
    found = 1'b0;
    pick = 6'h00;
    for (int k = NSRC - 1; k >= 0; k--) begin
      if (use_req[k]) begin
        found = 1'b1;
        pick = IPM_VEC_TABLE[k*6 +: 6]; // ties go to the smaller vector
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel.sel_valid <= 1'b0;
      sel.sel_level <= 1'b0;
      sel.sel_vec <= 6'h00;
    end else begin
      sel.sel_valid <= found;
      sel.sel_level <= any_hi;
      sel.sel_vec <= pick;
    end
  end
endmodule

// ==== verilog/ipm_top.sv ====
// Contract
// - timer 3 match a, match b, overflow use vectors 36-38 under prio b bit 7
// - timer 4 requests use 40-42 under prio b bit 6; 39, 43-51 reserved
// - serial 0 error, rx full, tx empty, tx end use 52-55, prio b bit 3
// - serial 1 uses 56-59 under bit 2; converter done uses 60 under bit 1
// - table address is vector times two, or times four in wide mode
// - mode bit 1 masks by i only; mode bit 0 masks by i and ui
// - nonmaskable request always accepted except during reset
// - a request reaches the arbiter only when its enable bit is set
// - highest level wins, ties broken by fixed vector order, others wait
// - mode 1: i set passes only nonmaskable; i clear passes selected request
// - mode 0 with i clear accepts any level regardless of ui
// - mode 0, i set, ui clear: nonmaskable and level 1 only
// - mode 0, i and ui set: only nonmaskable accepted
// - entry begins only after the current instruction completes
// - entry pushes pc and ccr; pushed pc is the return address
// - after saving in mode 1 the i bit is set
// - after saving in mode 0 both i and ui are set
// - table address of accepted request handed out to start the service routine
// - smaller vectors win by default; reset restores default order
// - nonmaskable uses vector 7 with selectable edge; pins 0,1,4,5 use 12,13,16,17
// - pins 0 and 1 own prio a bits 7 and 6; pins 4 and 5 share bit 4
//
// Purpose: interrupt arbitration and masking with vector hand-off to the cpu
// Assumes: all inputs synchronous to clk_i; cpu owns pc/ccr stacking
// Notes: registers on classic wishbone, byte offsets 0x0..0xC
`timescale 1ns/1ps
module ipm_top
  import ipm_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // sources
  input wire logic nonmaskable_pin_i,
  input wire logic [3:0] ext_irq_i,
  input wire logic timer3_match_a_request_i,
  input wire logic timer3_match_b_request_i,
  input wire logic timer3_overflow_request_i,
  input wire logic timer4_match_a_request_i,
  input wire logic timer4_match_b_request_i,
  input wire logic timer4_overflow_request_i,
  input wire logic serial0_error_request_i,
  input wire logic serial0_rx_full_request_i,
  input wire logic serial0_tx_empty_request_i,
  input wire logic serial0_tx_end_request_i,
  input wire logic serial1_error_request_i,
  input wire logic serial1_rx_full_request_i,
  input wire logic serial1_tx_empty_request_i,
  input wire logic serial1_tx_end_request_i,
  input wire logic converter_done_request_i,
  // cpu side
  input wire logic cpu_i_bit_i,
  input wire logic secondary_mask_bit_i,
  input wire logic insn_boundary_i,
  input wire logic entry_ack_i,
  input wire logic wide_addr_mode_i,
  output logic irq_req_o,
  output logic [5:0] irq_vec_o,
  output logic [15:0] irq_tbl_addr_o,
  output logic set_i_o,
  output logic set_ui_o
);
  ipm_sel_if sel_bus();
  ipm_state_t state_q, state_d;
  logic [1:0] sysctl_q;
  logic [7:0] pri_a_q;
  logic [7:0] pri_b_q;
  logic [19:0] enable_q;
  logic nmi_prev_q;
  logic nmi_pend_q;
  logic [31:0] rd_data;
  logic ack_q;
  logic mode_sel;
  logic nmi_edge;
  logic [8:0] grp_level;
  logic [IPM_NSRC-1:0] raw_req;
  logic [IPM_NSRC-1:0] en_req;
  logic [IPM_NSRC-1:0] lvl;
  logic [IPM_NSRC-1:0] pass_req;
  logic pass_lvl0;
  logic pass_lvl1;
  logic take_nmi;
  logic take_sel;
  logic offer_ok;
  logic [5:0] offer_vec;
  logic bus_req;
  logic bus_wr;

  assign mode_sel = sysctl_q[IPM_SYS_MODE_BIT];
  // nonmaskable edge picked by control bit
  assign nmi_edge = sysctl_q[IPM_SYS_EDGE_BIT] ? (nonmaskable_pin_i & ~nmi_prev_q)
                                                : (~nonmaskable_pin_i & nmi_prev_q);
  // groups: pin0, pin1, pin4/5, timer3, timer4, serial0, serial1, converter, spare
  assign grp_level = {1'b0, pri_b_q[1], pri_b_q[2], pri_b_q[3], pri_b_q[6], pri_b_q[7],
                      pri_a_q[4], pri_a_q[6], pri_a_q[7]};
  assign raw_req = {converter_done_request_i,
                    serial1_tx_end_request_i, serial1_tx_empty_request_i,
                    serial1_rx_full_request_i, serial1_error_request_i,
                    serial0_tx_end_request_i, serial0_tx_empty_request_i,
                    serial0_rx_full_request_i, serial0_error_request_i,
                    timer4_overflow_request_i, timer4_match_b_request_i,
                    timer4_match_a_request_i,
                    timer3_overflow_request_i, timer3_match_b_request_i,
                    timer3_match_a_request_i,
                    ext_irq_i}; // pins 0,1,4,5 as vectors 12,13,16,17
  assign en_req = raw_req & enable_q[IPM_NSRC-1:0];

  genvar g;
  generate
    for (g = 0; g < IPM_NSRC; g++) begin : g_lvl
      assign lvl[g] = grp_level[IPM_GRP_TABLE[g*4 +: 4]];
    end
  endgenerate

  // mask gating per level
  assign pass_lvl0 = ~cpu_i_bit_i;
  assign pass_lvl1 = mode_sel ? ~cpu_i_bit_i : ~(cpu_i_bit_i & secondary_mask_bit_i);
  assign pass_req = en_req & ((lvl & {IPM_NSRC{pass_lvl1}}) | (~lvl & {IPM_NSRC{pass_lvl0}}));

  // masked requests do not compete; gating before the arbiter keeps them pending
  ipm_arbiter #(
    .NSRC(IPM_NSRC)
  ) u_arb (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(pass_req),
    .lvl_i(lvl),
    .sel(sel_bus.arb)
  );

  // the registered choice is rechecked against the live mask to avoid a stale accept
  assign take_nmi = nmi_pend_q;
  assign take_sel = sel_bus.sel_valid &
                    (sel_bus.sel_level ? pass_lvl1 : pass_lvl0);
  assign offer_ok = (take_nmi | take_sel) & insn_boundary_i;
  assign offer_vec = take_nmi ? IPM_VEC_NMI : sel_bus.sel_vec;

  always_comb begin
    state_d = state_q;
    case (state_q)
      IPM_ST_IDLE: begin
        if (offer_ok) begin
          state_d = IPM_ST_OFFER;
        end
      end
      IPM_ST_OFFER: begin
        if (entry_ack_i) begin
          state_d = IPM_ST_ENTRY;
        end
      end
      IPM_ST_ENTRY: begin
        state_d = IPM_ST_IDLE;
      end
      default: begin
        state_d = IPM_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= IPM_ST_IDLE;
      irq_req_o <= 1'b0;
      irq_vec_o <= 6'h00;
      irq_tbl_addr_o <= 16'h0000;
      set_i_o <= 1'b0;
      set_ui_o <= 1'b0;
    end else begin
      state_q <= state_d;
      set_i_o <= 1'b0;
      set_ui_o <= 1'b0;
      if (state_q == IPM_ST_IDLE && offer_ok) begin
        irq_req_o <= 1'b1;
        irq_vec_o <= offer_vec;
        // low 16 bits of the table entry address
        irq_tbl_addr_o <= wide_addr_mode_i ? {8'h00, offer_vec, 2'b00} : {9'h000, offer_vec, 1'b0};
      end
      if (state_q == IPM_ST_OFFER && entry_ack_i) begin
        irq_req_o <= 1'b0;
        // cpu stacks pc and ccr on this pulse, then loads the mask
        set_i_o <= 1'b1;
        set_ui_o <= ~mode_sel;
      end
    end
  end

  // nonmaskable latch: edge sets, entry on vector 7 clears; set wins over clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      nmi_prev_q <= 1'b0;
      nmi_pend_q <= 1'b0; // reset drops it
    end else begin
      nmi_prev_q <= nonmaskable_pin_i;
      if (nmi_edge) begin
        nmi_pend_q <= 1'b1;
      end else if (state_q == IPM_ST_OFFER && entry_ack_i && irq_vec_o == IPM_VEC_NMI) begin
        nmi_pend_q <= 1'b0;
      end
    end
  end

  // wishbone slave, one wait cycle, unmapped reads give zero
  assign bus_req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign bus_wr = bus_req & wb_we_i & wb_sel_i[0];
  assign rd_data = (wb_adr_i == IPM_OFF_SYSCTL) ? {30'h00000000, sysctl_q} :
                   (wb_adr_i == IPM_OFF_PRIA) ? {24'h000000, pri_a_q} :
                   (wb_adr_i == IPM_OFF_PRIB) ? {24'h000000, pri_b_q} :
                   (wb_adr_i == IPM_OFF_ENABLE) ? {12'h000, enable_q} : 32'h00000000;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
      sysctl_q <= IPM_SYSCTL_RST;
      pri_a_q <= IPM_PRI_RST; // default order after reset
      pri_b_q <= IPM_PRI_RST;
      enable_q <= IPM_EN_RST;
    end else begin
      ack_q <= bus_req;
      wb_ack_o <= bus_req;
      wb_dat_o <= rd_data;
      if (bus_wr && wb_adr_i == IPM_OFF_SYSCTL) begin
        sysctl_q <= wb_dat_i[1:0];
      end
      if (bus_wr && wb_adr_i == IPM_OFF_PRIA) begin
        pri_a_q <= wb_dat_i[7:0];
      end
      if (bus_wr && wb_adr_i == IPM_OFF_PRIB) begin
        pri_b_q <= wb_dat_i[7:0];
      end
      if (bus_req && wb_we_i && wb_adr_i == IPM_OFF_ENABLE) begin
        if (wb_sel_i[0]) begin
          enable_q[7:0] <= wb_dat_i[7:0];
        end
        if (wb_sel_i[1]) begin
          enable_q[15:8] <= wb_dat_i[15:8];
        end
        if (wb_sel_i[2]) begin
          enable_q[19:16] <= wb_dat_i[19:16];
        end
      end
    end
  end
endmodule

// ==== tb/ipm_top_chk.sv ====
// Purpose: port-level checks for ipm_top
// Assumes: one clock, rst_i synchronous active high
// Notes: bound to every ipm_top below the module
`timescale 1ns/1ps
module ipm_top_chk (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic cpu_i_bit_i,
  input wire logic secondary_mask_bit_i,
  input wire logic insn_boundary_i,
  input wire logic entry_ack_i,
  input wire logic wide_addr_mode_i,
  input wire logic irq_req_o,
  input wire logic [5:0] irq_vec_o,
  input wire logic [15:0] irq_tbl_addr_o,
  input wire logic set_i_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("bus request not answered");
  tbl_addr_a: assert property (irq_req_o |-> irq_tbl_addr_o == (wide_addr_mode_i ?
    {8'h00, irq_vec_o, 2'b00} : {9'h000, irq_vec_o, 1'b0})) else $error("table address wrong");
  vec_legal_a: assert property (irq_req_o |-> irq_vec_o inside {7, 12, 13, 16, 17, [36:38], [40:42], [52:60]})
    else $error("vector outside the table");
  offer_edge_a: assert property ($rose(irq_req_o) |-> $past(insn_boundary_i)) else $error("offer off boundary");
  req_hold_a: assert property (irq_req_o && !entry_ack_i |=> irq_req_o && $stable(irq_vec_o))
    else $error("offer dropped early");
  req_drop_a: assert property (irq_req_o && entry_ack_i |=> !irq_req_o [*2]) else $error("offer kept after ack");
  set_mask_a: assert property (irq_req_o && entry_ack_i |=> set_i_o) else $error("mask set missing");
  set_cause_a: assert property (set_i_o |-> $past(irq_req_o && entry_ack_i)) else $error("stray mask set");
  nmi_only_a: assert property ($rose(irq_req_o) && $past(cpu_i_bit_i && secondary_mask_bit_i) |->
    irq_vec_o == 6'h07) else $error("masked request offered");
  cover property (irq_req_o && entry_ack_i && irq_vec_o == 6'h07);
  cover property ($rose(irq_req_o) && wide_addr_mode_i);
  cover property (wb_ack_o && wb_cyc_i);
endmodule

bind ipm_top ipm_top_chk ipm_top_chk_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .cpu_i_bit_i,
  .secondary_mask_bit_i, .insn_boundary_i, .entry_ack_i, .wide_addr_mode_i, .irq_req_o, .irq_vec_o,
  .irq_tbl_addr_o, .set_i_o);

// ==== tb/ipm_cpu_model.sv ====
// Purpose: cpu exception sequencer standing at the unit's far side
// Assumes: shares the unit's clock and reset
// Notes: a short countdown stands in for the service routine and its return
`timescale 1ns/1ps
module ipm_cpu_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic req_i,
  input wire logic set_i_i,
  input wire logic set_ui_i,
  input wire logic ld_i,
  input wire logic ld_ibit_i,
  input wire logic ld_uibit_i,
  input wire logic slow_i,
  output logic boundary_o,
  output logic ack_o,
  output logic ibit_o,
  output logic uibit_o
);
  logic [1:0] bcnt_q;
  logic [2:0] rte_q;
  logic sv_i_q;
  logic sv_ui_q;
  // slow mode ends an instruction only every fourth cycle
  assign boundary_o = bcnt_q == 2'h0;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {bcnt_q, rte_q, ack_o, ibit_o, uibit_o, sv_i_q, sv_ui_q} <= {5'h00, 5'h0F};
    end else begin
      bcnt_q <= slow_i ? bcnt_q + 2'h1 : 2'h0;
      ack_o <= req_i && !ack_o && boundary_o;
      if (ack_o && req_i) begin
        {sv_i_q, sv_ui_q, rte_q} <= {ibit_o, uibit_o, 3'h6};
      end else if (rte_q != 3'h0) begin
        rte_q <= rte_q - 3'h1;
      end
      if (ld_i) begin
        {ibit_o, uibit_o} <= {ld_ibit_i, ld_uibit_i};
      end else if (rte_q == 3'h1) begin
        {ibit_o, uibit_o} <= {sv_i_q, sv_ui_q};
      end else begin
        ibit_o <= ibit_o | set_i_i;
        uibit_o <= uibit_o | set_ui_i;
      end
    end
  end
endmodule

// ==== tb/test_interrupt_priority_mask_unit.sv ====
// Purpose: self-checking bench for ipm_top with a cpu model
// Assumes: 100 MHz clock, reset held 10 cycles
// Notes: served vectors are noted in a queue and checked by a monitor
`timescale 1ns/1ps
module test_interrupt_priority_mask_unit;
  import ipm_pkg::*;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, nmi = 1, wide = 0, slow = 0;
  logic ld = 0, ldi = 0, ldui = 0, mode_b = 1, p = 0;
  logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd, seed = 32'h16A1;
  logic wb_ack_o, insn_boundary_i, entry_ack_i, cpu_i_bit_i, secondary_mask_bit_i, irq_req_o, set_i_o, set_ui_o;
  logic [5:0] irq_vec_o;
  logic [15:0] irq_tbl_addr_o, pri;
  logic [18:0] src = 19'h0, en, pend;
  logic [6:0] e;
  logic [6:0] q[$];
  logic [3:0] al[5] = '{4'h0, 4'h4, 4'h8, 4'hC, 4'h2};
  int bad_count = 0, n_tests = 0, cyc_n = 0;
  int vtab[19] = '{12, 13, 16, 17, 36, 37, 38, 40, 41, 42, 52, 53, 54, 55, 56, 57, 58, 59, 60};
  int gtab[19] = '{15, 14, 12, 12, 7, 7, 7, 6, 6, 6, 3, 3, 3, 3, 2, 2, 2, 2, 1};
  ipm_top ipm_top_i (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .nonmaskable_pin_i(nmi), .ext_irq_i(src[3:0]), .timer3_match_a_request_i(src[4]),
    .timer3_match_b_request_i(src[5]), .timer3_overflow_request_i(src[6]), .timer4_match_a_request_i(src[7]),
    .timer4_match_b_request_i(src[8]), .timer4_overflow_request_i(src[9]), .serial0_error_request_i(src[10]),
    .serial0_rx_full_request_i(src[11]), .serial0_tx_empty_request_i(src[12]), .serial0_tx_end_request_i(src[13]),
    .serial1_error_request_i(src[14]), .serial1_rx_full_request_i(src[15]), .serial1_tx_empty_request_i(src[16]),
    .serial1_tx_end_request_i(src[17]), .converter_done_request_i(src[18]), .cpu_i_bit_i, .secondary_mask_bit_i,
    .insn_boundary_i, .entry_ack_i, .wide_addr_mode_i(wide), .irq_req_o, .irq_vec_o, .irq_tbl_addr_o, .set_i_o,
    .set_ui_o);
  ipm_cpu_model ipm_cpu_model_i (.clk_i, .rst_i, .req_i(irq_req_o), .set_i_i(set_i_o), .set_ui_i(set_ui_o),
    .ld_i(ld), .ld_ibit_i(ldi), .ld_uibit_i(ldui), .slow_i(slow), .boundary_o(insn_boundary_i),
    .ack_o(entry_ack_i), .ibit_o(cpu_i_bit_i), .uibit_o(secondary_mask_bit_i));
  always #5 clk_i = ~clk_i;
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    return s ^ (s << 5);
  endfunction
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, w, a, d};
    do begin @(posedge clk_i); n++; end while (wb_ack_o !== 1'b1 && n < 20);
    chk(32'(n < 20), 32'h1);
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic mask(input logic i, input logic ui);
    @(posedge clk_i);
    {ld, ldi, ldui} <= {1'b1, i, ui};
    @(posedge clk_i);
    ld <= 1'b0;
  endtask
  // give late offers time to show, so an unexpected one pops an empty note
  task automatic drain();
    int n;
    n = 0;
    while (q.size() != 0 && n < 400) begin @(posedge clk_i); n++; end
    chk(32'(q.size()), 32'h0);
    repeat (20) @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (p) chk({set_i_o, set_ui_o}, {1'b1, e[6]});
    p = 0;
    if (irq_req_o === 1'b1 && entry_ack_i === 1'b1) begin
      e = (q.size() != 0) ? q.pop_front() : 7'h7F;
      chk(irq_vec_o, e[5:0]);
      chk(irq_tbl_addr_o, wide ? {8'h00, e[5:0], 2'b00} : {9'h000, e[5:0], 1'b0});
      for (int j = 0; j < 19; j++) if (vtab[j] == irq_vec_o) src[j] <= 1'b0;
      p = 1;
    end
    if (++cyc_n > 30000) begin bad_count++; give_verdict(); end
  end
  initial begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b1, 4'h2, 32'hFFFFFFFF);
    for (int k = 0; k < 5; k++) begin wb(1'b0, al[k], 32'h0); chk(rd, k == 0 ? 32'h2 : 32'h0); end
    mask(1'b0, 1'b0);
    for (int r = 0; r < 8; r++) begin
      seed = xs(seed);
      en = r == 0 ? 19'h7FFFF : seed[18:0];
      slow <= seed[31];
      seed = xs(seed);
      pend = r == 0 ? 19'h7FFFF : seed[18:0];
      wide <= seed[31];
      seed = xs(seed);
      pri = r == 0 ? 16'h0 : seed[15:0];
      wb(1'b1, IPM_OFF_ENABLE, {13'h0, en});
      wb(1'b1, IPM_OFF_PRIA, {24'h0, pri[15:8]});
      wb(1'b1, IPM_OFF_PRIB, {24'h0, pri[7:0]});
      for (int l = 1; l >= 0; l--) for (int j = 0; j < 19; j++)
        if (en[j] && pend[j] && pri[gtab[j]] == l[0]) q.push_back({~mode_b, 6'(vtab[j])});
      src <= pend;
      drain();
      src <= 19'h0;
    end
    wb(1'b1, IPM_OFF_ENABLE, 32'h7FFFF);
    wb(1'b1, IPM_OFF_PRIA, 32'h0);
    wb(1'b1, IPM_OFF_PRIB, 32'h8);
    wb(1'b1, IPM_OFF_SYSCTL, 32'h0);
    {wide, slow, mode_b} <= 3'h0;
    mask(1'b1, 1'b0);
    q.push_back({1'b1, 6'd53});
    src <= 19'h00810;
    drain();
    mask(1'b1, 1'b1);
    nmi <= 1'b0;
    q.push_back({1'b1, 6'h07});
    drain();
    mask(1'b0, 1'b1);
    q.push_back({1'b1, 6'd36});
    drain();
    wb(1'b1, IPM_OFF_SYSCTL, 32'h3);
    mode_b = 1'b1;
    mask(1'b1, 1'b0);
    src <= 19'h00800;
    nmi <= 1'b1;
    q.push_back({1'b0, 6'h07});
    drain();
    nmi <= 1'b0;
    drain();
    mask(1'b0, 1'b0);
    q.push_back({1'b0, 6'd53});
    drain();
    give_verdict();
  end
endmodule
